// ===== hw/ifdb_pkg.sv
// Constants shared by the interrupt flag and DMA burst block
// Overview of operation
// - Burst channel keeps transferring until count zero
// - Burst select register, one bit per channel
// - Vanished request answers with default vector
// - Level mode passes pin straight to request
// - Edge to level switch clears the flag
// - Level to edge switch keeps flags
// - Receive flag cleared only by reset or read
// - Level pin drop lowers the request but leaves the latched flag set
// - Count zero raises end flag, clears start vector
package ifdb_pkg;

	localparam int NUM_CH  = 8;
	localparam int NUM_EXT = 4;
	localparam int CNT_W   = 16;
	localparam int SVEC_W  = 6;
	localparam int VEC_W   = 16;
	localparam int ST_W    = 13;
	localparam int ADDR_W  = 12;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_START_VEC0 = 10'h100;
	localparam logic [9:0] IDX_BURST      = 10'h108;
	localparam logic [9:0] IDX_MODE       = 10'h109;
	localparam logic [9:0] IDX_STATUS     = 10'h10a;
	localparam logic [9:0] IDX_CLEAR      = 10'h10b;
	localparam logic [9:0] IDX_ENABLE     = 10'h10c;
	localparam logic [9:0] IDX_COUNT0     = 10'h110;

	// Status layout
	localparam int ST_EXT_LSB = 0;
	localparam int ST_RX_BIT  = 4;
	localparam int ST_END_LSB = 5;

	// Reset values
	localparam logic [7:0]        BURST_RST  = 8'h00;
	localparam logic [3:0]        MODE_RST   = 4'h0;
	localparam logic [ST_W-1:0]   ENABLE_RST = 13'h0000;
	localparam logic [SVEC_W-1:0] SVEC_RST   = 6'h00;
	localparam logic [CNT_W-1:0]  COUNT_RST  = 16'h0000;

	// Vectors
	localparam logic [VEC_W-1:0] DEFAULT_VEC  = 16'h0004;
	localparam logic [VEC_W-1:0] SRC_VEC_BASE = 16'h0020;

	typedef enum logic {DMA_IDLE, DMA_RUN} ifdb_dma_state_t;

endpackage : ifdb_pkg

// ===== hw/ifdb_ext_flag.sv
// Request flag for one external interrupt input, edge or level mode
`timescale 1ns/100ps
`default_nettype none
module ifdb_ext_flag
	import ifdb_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic pinIn,
	input  wire logic levelMode,
	input  wire logic clearReq,
	output logic      request
);

	logic pinPrev;
	logic modePrev;
	logic latched;
	logic setReq;
	logic clrReq;
	logic next_latched;

	// Edge sets in edge mode; in level mode the pin drives the set path
	assign setReq = levelMode ? pinIn : (pinIn & ~pinPrev);
	assign clrReq = clearReq | (levelMode & ~modePrev);
	// Set wins over clear; leaving level mode touches nothing
	assign next_latched = setReq ? 1'b1 : (clrReq ? 1'b0 : latched);
	// Level mode bypasses the latch, so a pin drop lowers the request but leaves the latch set
	assign request = levelMode ? pinIn : latched;

	// Flag and history
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pinPrev  <= 1'b0;
			modePrev <= 1'b0;
			latched  <= 1'b0;
		end else begin
			pinPrev  <= pinIn;
			modePrev <= levelMode;
			latched  <= next_latched;
		end
	end

endmodule : ifdb_ext_flag
`default_nettype wire

// ===== hw/ifdb_top.sv
// Interrupt request flags, vector answer and DMA burst control
`timescale 1ns/100ps
`default_nettype none
module ifdb_top
	import ifdb_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// External request pins
	input  wire logic [NUM_EXT-1:0] extIrqIn,
	// Serial receive events
	input  wire logic              rxEvent,
	input  wire logic              rxBufRead,
	// Vector fetch
	input  wire logic              vecReq,
	input  wire logic [3:0]        vecSrc,
	output logic                   vecValid,
	output logic      [VEC_W-1:0]  vecData,
	// DMA start and bus transfer
	input  wire logic              srcReq,
	input  wire logic [SVEC_W-1:0] srcVec,
	output logic                   dmaXferReq,
	output logic      [2:0]        dmaXferCh,
	input  wire logic              dmaXferAck,
	// Interrupt out
	output logic                   irq
);

	// Word index decode
	function automatic logic isReg(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
		isReg = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
	endfunction : isReg

	// Lowest set bit of a channel mask
	function automatic logic [2:0] lowest(input logic [NUM_CH-1:0] m);
		lowest = 3'd0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (m[i]) begin
				lowest = i[2:0];
			end
		end
	endfunction : lowest

	// Vector assigned to each status source
	function automatic logic [VEC_W-1:0] srcVector(input logic [3:0] s);
		srcVector = SRC_VEC_BASE + {10'h000, s, 2'b00};
	endfunction : srcVector

	// One-hot bit of a channel
	function automatic logic [NUM_CH-1:0] chanBit(input logic [2:0] ch);
		chanBit = 8'h01 << ch;
	endfunction : chanBit

	// Eight-word bank decode for the per-channel registers
	function automatic logic inBank(input logic [ADDR_W-1:0] a, input logic [9:0] base);
		inBank = (a[ADDR_W-1:5] == base[9:3]) && (a[1:0] == 2'b00);
	endfunction : inBank

	logic [7:0]        burstSel;
	logic [3:0]        extMode;
	logic [ST_W-1:0]   irqEnable;
	logic              rxFlag;
	logic [NUM_CH-1:0] endFlag;
	logic [NUM_CH-1:0] pend;
	logic [SVEC_W-1:0] startVec [NUM_CH];
	logic [CNT_W-1:0]  xferCount [NUM_CH];
	logic [2:0]        actCh;
	ifdb_dma_state_t   dmaState;
	logic [NUM_EXT-1:0] extReq;
	logic [NUM_EXT-1:0] extClear;
	logic [ST_W-1:0]   status;

	// Bus decode
	logic              accessPh;
	logic              wrEn;
	logic              rdSel;
	logic [9:0]        wIdx;
	logic              hitStart;
	logic              hitCount;
	logic              hitBurst;
	logic              hitMode;
	logic              hitStatus;
	logic              hitClear;
	logic              hitEnable;
	logic              mapped;
	logic [2:0]        regCh;
	logic [31:0]       next_prdata;
	logic              wrStart;
	logic              wrCount;

	assign accessPh  = psel & penable;
	assign wIdx      = paddr[ADDR_W-1:2];
	assign regCh     = wIdx[2:0];
	assign hitStart  = inBank(paddr, IDX_START_VEC0);
	assign hitCount  = inBank(paddr, IDX_COUNT0);
	assign hitBurst  = isReg(paddr, IDX_BURST);
	assign hitMode   = isReg(paddr, IDX_MODE);
	assign hitStatus = isReg(paddr, IDX_STATUS);
	assign hitClear  = isReg(paddr, IDX_CLEAR);
	assign hitEnable = isReg(paddr, IDX_ENABLE);
	assign mapped    = hitStart | hitCount | hitBurst | hitMode | hitStatus
	                 | hitClear | hitEnable;
	// Write lands on the edge where the master sees pready
	assign wrEn      = accessPh & pready & pwrite & mapped;
	assign rdSel     = accessPh & ~pready & ~pwrite;
	// Per-channel writes; the sequencer still wins on the same edge
	assign wrStart   = wrEn & hitStart;
	assign wrCount   = wrEn & hitCount;

	// Read mux; clear register reads as zero
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (hitStart) begin
			next_prdata = {26'h000_0000, startVec[regCh]};
		end else if (hitCount) begin
			next_prdata = {16'h0000, xferCount[regCh]};
		end else if (hitBurst) begin
			next_prdata = {24'h00_0000, burstSel};
		end else if (hitMode) begin
			next_prdata = {28'h000_0000, extMode};
		end else if (hitStatus) begin
			next_prdata = {19'h0_0000, status};
		end else if (hitEnable) begin
			next_prdata = {19'h0_0000, irqEnable};
		end
	end

	// One wait state, then the answer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= accessPh & ~pready;
			pslverr <= accessPh & ~pready & ~mapped;
			prdata  <= rdSel ? next_prdata : 32'h0000_0000;
		end
	end

	// Software registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			burstSel  <= BURST_RST;
			extMode   <= MODE_RST;
			irqEnable <= ENABLE_RST;
		end else if (wrEn) begin
			if (hitBurst) begin
				burstSel <= pwdata[7:0];
			end
			if (hitMode) begin
				extMode <= pwdata[3:0];
			end
			if (hitEnable) begin
				irqEnable <= pwdata[ST_W-1:0];
			end
		end
	end

	// Vector fetch clears the accepted flag, except the receive flag
	logic              vecHit;
	logic [ST_W-1:0]   vecClr;
	logic [ST_W-1:0]   wrClr;
	logic              vecFlagSet;

	assign vecHit     = vecReq & (vecSrc < 4'(ST_W));
	assign vecFlagSet = vecHit & status[vecSrc];
	assign vecClr     = vecFlagSet ? (13'h0001 << vecSrc) : 13'h0000;
	assign wrClr      = (wrEn & hitClear) ? pwdata[ST_W-1:0] : 13'h0000;

	// External flag cells
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
			assign extClear[gi] = wrClr[ST_EXT_LSB + gi] | vecClr[ST_EXT_LSB + gi];
			ifdb_ext_flag u_flag (
				.clock     (clock),
				.rst_n     (rst_n),
				.pinIn     (extIrqIn[gi]),
				.levelMode (extMode[gi]),
				.clearReq  (extClear[gi]),
				.request   (extReq[gi])
			);
		end
	endgenerate

	// Receive flag ignores the clear register and vector fetch
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rxFlag <= 1'b0;
		end else if (rxEvent) begin
			rxFlag <= 1'b1;
		end else if (rxBufRead) begin
			rxFlag <= 1'b0;
		end
	end

	assign status = {endFlag, rxFlag, extReq};

	// Vector answer; a flag gone by the fetch gets the default
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			vecValid <= 1'b0;
			vecData  <= DEFAULT_VEC;
		end else begin
			vecValid <= vecReq;
			if (vecReq) begin
				vecData <= vecFlagSet ? srcVector(vecSrc) : DEFAULT_VEC;
			end
		end
	end

	// Level interrupt output
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & irqEnable);
		end
	end

	// DMA start matching; lowest channel takes a shared vector
	logic [NUM_CH-1:0] match;
	logic [NUM_CH-1:0] startHit;
	logic [NUM_CH-1:0] takeMask;
	logic [NUM_CH-1:0] endSet;
	logic              lastXfer;
	logic              doneXfer;
	logic              grab;
	logic [2:0]        grabCh;
	logic [NUM_CH-1:0] live;
	logic [NUM_CH-1:0] pendLive;
	logic              singleDone;

	// A channel is live while it has a start vector and a count left
	always_comb begin
		match = '0;
		live  = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			live[i]  = (startVec[i] != SVEC_RST) && (xferCount[i] != COUNT_RST);
			match[i] = srcReq && (startVec[i] == srcVec) && live[i];
		end
	end

	// A start caught on the last transfer's edge must not rerun the channel at count 0
	assign pendLive   = pend & live;
	assign startHit   = (|match) ? chanBit(lowest(match)) : 8'h00;
	assign grab       = (dmaState == DMA_IDLE) && (|pendLive);
	assign grabCh     = lowest(pendLive);
	assign takeMask   = grab ? chanBit(grabCh) : 8'h00;
	assign doneXfer   = (dmaState == DMA_RUN) && dmaXferAck;
	assign lastXfer   = doneXfer && (xferCount[actCh] == 16'h0001);
	assign singleDone = doneXfer && !burstSel[actCh];
	assign endSet     = lastXfer ? chanBit(actCh) : 8'h00;

	// Pending starts; a new start wins over the take
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pend <= '0;
		end else begin
			pend <= (pendLive & ~takeMask) | startHit;
		end
	end

	// End flags; hardware set wins over software clear
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			endFlag <= '0;
		end else begin
			endFlag <= (endFlag & ~wrClr[ST_END_LSB +: NUM_CH]
			          & ~vecClr[ST_END_LSB +: NUM_CH]) | endSet;
		end
	end

	// Start vectors and counters; hardware update wins over the bus
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				startVec[i]  <= SVEC_RST;
				xferCount[i] <= COUNT_RST;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (lastXfer && (actCh == i[2:0])) begin
					startVec[i] <= SVEC_RST;
				end else if (wrStart && (regCh == i[2:0])) begin
					startVec[i] <= pwdata[SVEC_W-1:0];
				end
				if (doneXfer && (actCh == i[2:0])) begin
					xferCount[i] <= xferCount[i] - 16'h0001;
				end else if (wrCount && (regCh == i[2:0])) begin
					xferCount[i] <= pwdata[CNT_W-1:0];
				end
			end
		end
	end

	// Transfer sequencer; bus goes back to the CPU between single transfers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dmaState   <= DMA_IDLE;
			dmaXferReq <= 1'b0;
			dmaXferCh  <= 3'd0;
			actCh      <= 3'd0;
		end else begin
			case (dmaState)
				DMA_IDLE: begin
					if (grab) begin
						actCh      <= grabCh;
						dmaXferCh  <= grabCh;
						dmaXferReq <= 1'b1;
						dmaState   <= DMA_RUN;
					end
				end
				DMA_RUN: begin
					if (lastXfer) begin
						dmaXferReq <= 1'b0;
						dmaState   <= DMA_IDLE;
					end else if (singleDone) begin
						dmaXferReq <= 1'b0;
						dmaState   <= DMA_IDLE;
					end
					// Burst keeps the request up until the count runs out
				end
				default: begin
					dmaState   <= DMA_IDLE;
					dmaXferReq <= 1'b0;
				end
			endcase
		end
	end

endmodule : ifdb_top
`default_nettype wire

// ===== dv/ifdb_checker_asserts.sv
// Port assertions for the interrupt flag and DMA burst block
`timescale 1ns/100ps
`default_nettype none
module ifdb_checker
	import ifdb_pkg::*;
(
	input wire logic              clock,
	input wire logic              rst_n,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [NUM_EXT-1:0] extIrqIn,
	input wire logic              vecReq,
	input wire logic [3:0]        vecSrc,
	input wire logic [VEC_W-1:0]  vecData,
	input wire logic              vecValid,
	input wire logic              dmaXferReq,
	input wire logic [2:0]        dmaXferCh,
	input wire logic              dmaXferAck,
	input wire logic              irq
);
	logic [7:0]  burstSh;
	logic [3:0]  modeSh;
	logic [12:0] enSh;
	wire logic   wrDone = psel & penable & pready & pwrite;

	// Shadow control writes at the edge where they land
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			burstSh <= 8'h00;
			modeSh <= 4'h0;
			enSh <= 13'h0000;
		end else if (wrDone) begin
			if (paddr == {IDX_BURST, 2'h0}) burstSh <= pwdata[7:0];
			if (paddr == {IDX_MODE, 2'h0}) modeSh <= pwdata[3:0];
			if (paddr == {IDX_ENABLE, 2'h0}) enSh <= pwdata[12:0];
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_rdy_pulse;
		pready |=> !pready;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
	property p_rdy_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
	property p_err_zero;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("error with data");
	property p_vec_valid;
		vecReq |=> vecValid;
	endproperty
	a_vec_valid: assert property (p_vec_valid) else $error("no vector answer");
	property p_vec_default;
		vecReq && vecSrc >= 4'hd |=> vecData == DEFAULT_VEC;
	endproperty
	a_vec_default: assert property (p_vec_default) else $error("bad default");
	property p_vec_hold;
		!vecReq |=> $stable(vecData);
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
	property p_xfer_hold;
		dmaXferReq && !dmaXferAck |=> dmaXferReq && $stable(dmaXferCh);
	endproperty
	a_xfer_hold: assert property (p_xfer_hold) else $error("transfer dropped");
	property p_single;
		dmaXferAck && !burstSh[dmaXferCh] |=> !dmaXferReq;
	endproperty
	a_single: assert property (p_single) else $error("extra transfer");
	property p_level_irq;
		modeSh[0] && enSh == 13'h0001 && extIrqIn[0] |=> irq;
	endproperty
	a_level_irq: assert property (p_level_irq) else $error("level not seen");
	property p_level_drop;
		modeSh[0] && enSh == 13'h0001 && !extIrqIn[0] |=> !irq;
	endproperty
	a_level_drop: assert property (p_level_drop) else $error("level stuck");
endmodule : ifdb_checker

bind ifdb_top ifdb_checker u_chk (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .extIrqIn, .vecReq, .vecSrc, .vecData, .vecValid,
	.dmaXferReq, .dmaXferCh, .dmaXferAck, .irq);
`default_nettype wire

// ===== dv/ifdb_bus_partner.sv
// Bus side model answering DMA transfer requests
`timescale 1ns/100ps
`default_nettype none
module ifdb_bus_partner (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic dmaXferReq,
	input wire logic slow,
	output logic     dmaXferAck
);
	logic gap;

	// Never two acks in a row, so a final ack is not followed by a stray one
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dmaXferAck <= 1'h0;
			gap <= 1'h0;
		end else begin
			gap <= slow & ~gap;
			dmaXferAck <= dmaXferReq & ~dmaXferAck & ~gap;
		end
	end
endmodule : ifdb_bus_partner
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the interrupt flag and DMA burst block
`timescale 1ns/100ps
`default_nettype none
module tb
	import ifdb_pkg::*;
;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  extIrqIn, vecSrc;
	logic rxEvent, rxBufRead, vecReq, vecValid, srcReq, dmaXferReq, dmaXferAck, irq;
	logic [15:0] vecData;
	logic [5:0]  srcVec;
	logic [2:0]  dmaXferCh;
	int n_errors, checks_done, acks, cyc;

	ifdb_top u_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .extIrqIn, .rxEvent, .rxBufRead, .vecReq, .vecSrc, .vecValid,
		.vecData, .srcReq, .srcVec, .dmaXferReq, .dmaXferCh, .dmaXferAck, .irq);
	ifdb_bus_partner u_bus (.clock, .rst_n, .dmaXferReq, .slow, .dmaXferAck);

	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end

	// Ack tally and hang guard
	always @(posedge clock) begin
		cyc++;
		if (dmaXferAck === 1'h1) acks++;
		if (cyc == 5000) begin
			n_errors++;
			close_out();
		end
	end

	task automatic close_out;
		$display("Checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : cmp

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	// One APB transfer; holds the request until pready is sampled
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) n_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask : apb

	task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
		apb(1'h0, idx, 32'h0);
		cmp(rd, exp);
	endtask : rdc

	task automatic vec(input logic [3:0] s, input logic [15:0] exp);
		vecReq <= 1'h1;
		vecSrc <= s;
		tick(1);
		vecReq <= 1'h0;
		tick(1);
		cmp(vecValid, 32'h1);
		cmp(vecData, exp);
	endtask : vec

	task automatic t_regs;
		rdc(IDX_BURST, 32'h0);
		apb(1'h1, IDX_BURST, 32'ha5);
		rdc(IDX_BURST, 32'ha5);
		rdc(10'h3ff, 32'h0);
		cmp(err, 32'h1);
	endtask : t_regs

	task automatic t_dma(input int ch, input logic b, input int cnt, input int nAck);
		int n;
		n = 0;
		slow <= (ch == 0);
		apb(1'h1, IDX_BURST, b ? (32'h1 << ch) : 32'h0);
		apb(1'h1, IDX_START_VEC0 + 10'(ch), 32'h11 + 32'(ch));
		apb(1'h1, IDX_COUNT0 + 10'(ch), 32'(cnt));
		apb(1'h1, IDX_ENABLE, 32'h20 << ch);
		acks = 0;
		srcReq <= 1'h1;
		srcVec <= 6'h11 + 6'(ch);
		tick(1);
		srcReq <= 1'h0;
		while (dmaXferReq !== 1'h1 && n < 10) begin
			tick(1);
			n++;
		end
		cmp(dmaXferCh, 32'(ch));
		while (dmaXferReq === 1'h1 && n < 200) begin
			tick(1);
			n++;
		end
		tick(2);
		cmp(acks, nAck);
		rdc(IDX_COUNT0 + 10'(ch), 32'(cnt - nAck));
		rdc(IDX_START_VEC0 + 10'(ch), b ? 32'h0 : 32'h11 + 32'(ch));
		cmp(irq, 32'(b));
		apb(1'h1, IDX_CLEAR, 32'h20 << ch);
		tick(2);
		cmp(irq, 32'h0);
		apb(1'h1, IDX_ENABLE, 32'h0);
		rdc(IDX_STATUS, 32'h0);
	endtask : t_dma

	task automatic t_vec;
		extIrqIn <= 4'h2;
		tick(3);
		extIrqIn <= 4'h0;
		vec(4'h1, SRC_VEC_BASE + 16'h4);
		extIrqIn <= 4'h2;
		tick(3);
		extIrqIn <= 4'h0;
		apb(1'h1, IDX_CLEAR, 32'h2);
		vec(4'h1, DEFAULT_VEC);
		vec(4'hd, DEFAULT_VEC);
	endtask : t_vec

	task automatic t_level;
		apb(1'h1, IDX_ENABLE, 32'h1);
		extIrqIn <= 4'h1;
		tick(3);
		extIrqIn <= 4'h0;
		apb(1'h1, IDX_MODE, 32'h1);
		rdc(IDX_STATUS, 32'h0);
		// Back to edge with the pin low: only the latch can show here
		apb(1'h1, IDX_MODE, 32'h0);
		rdc(IDX_STATUS, 32'h0);
		apb(1'h1, IDX_MODE, 32'h1);
		extIrqIn <= 4'h1;
		tick(3);
		rdc(IDX_STATUS, 32'h1);
		cmp(irq, 32'h1);
		extIrqIn <= 4'h0;
		tick(3);
		rdc(IDX_STATUS, 32'h0);
		extIrqIn <= 4'h1;
		tick(3);
		apb(1'h1, IDX_MODE, 32'h0);
		extIrqIn <= 4'h0;
		rdc(IDX_STATUS, 32'h1);
		// Clear register is a bit mask here; input 0 is bit 0
		apb(1'h1, IDX_CLEAR, 32'h1);
		rdc(IDX_STATUS, 32'h0);
		apb(1'h1, IDX_ENABLE, 32'h0);
	endtask : t_level

	task automatic t_rx;
		rxEvent <= 1'h1;
		tick(1);
		rxEvent <= 1'h0;
		rdc(IDX_STATUS, 32'h10);
		apb(1'h1, IDX_CLEAR, 32'h10);
		rdc(IDX_STATUS, 32'h10);
		rxBufRead <= 1'h1;
		tick(1);
		rxBufRead <= 1'h0;
		rdc(IDX_STATUS, 32'h0);
	endtask : t_rx

	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, extIrqIn, vecSrc, srcVec} = '0;
		{rxEvent, rxBufRead, vecReq, srcReq, slow, rst_n} = '0;
		tick(16);
		rst_n <= 1'h1;
		// No mask level ever moves, so no status pop needs masking
		t_regs();
		t_dma(0, 1'h1, 3, 3);
		t_dma(7, 1'h1, 1, 1);
		t_dma(1, 1'h0, 3, 1);
		t_vec();
		t_level();
		t_rx();
		close_out();
	end
endmodule : tb
`default_nettype wire
